// File: bench/fabric_model.sv
// Routing fabric and global clock model feeding the logic cell
`timescale 1ns/100ps
`default_nettype none

module fabric_model
(
	// Clock
	input wire logic core_clk,
	// Routed levels asked for by the bench
	input wire logic [3:0] rc_val,
	// Sources into the cell
	output logic [7:0] global_clk,
	output logic bus_clk_app,
	output logic [3:0] routed_ctl_in
);
	int cnt = 0;
	initial global_clk = 8'h00;
	initial bus_clk_app = 1'b0;
	// Each level lasts at least one core cycle, else the edge detect would miss it
	always @(posedge core_clk)
	begin
		cnt <= cnt + 1;
		bus_clk_app <= ~bus_clk_app;
		for (int n = 0; n < 8; n++)
			if ((cnt % (n + 2)) == 0)
				global_clk[n] <= ~global_clk[n];
	end
	// Enable levels come from the bench, which toggles them no faster than half rate
	assign routed_ctl_in = rc_val;
endmodule : fabric_model
`default_nettype wire

// File: bench/testbench.sv
// Self-checking bench of the logic cell clock/reset control
`timescale 1ns/100ps
`default_nettype none
`include "cell_clkrst_defines.svh"

module testbench;
	logic core_clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	logic pready, pslverr, err, bus_clk_app, fifo0_tick, fifo1_tick;
	logic la_reset, dp_reset, st_reset, ctl_reset, status_irq_allowed, mask_is_period;
	logic [7:0] global_clk;
	logic [3:0] routed_ctl_in, clk_tick, rc_val = 4'h0;
	int n_fail = 0, samples_checked = 0, cycles = 0;
	logic [31:0] rnd = 32'h9e53_ac55;
	logic chk_on = 1'b0, inv_s = 1'b0, gate = 1'b0, h1 = 1'b0, h2 = 1'b0;
	logic [1:0] ci = 2'h0;
	logic [3:0] src_i = 4'h0;

	logic_cell_clock_reset_ctrl DUT (.core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.global_clk(global_clk), .bus_clk_app(bus_clk_app), .routed_ctl_in(routed_ctl_in), .clk_tick(clk_tick),
		.fifo0_tick(fifo0_tick), .fifo1_tick(fifo1_tick), .la_reset(la_reset), .dp_reset(dp_reset),
		.st_reset(st_reset), .ctl_reset(ctl_reset), .status_irq_allowed(status_irq_allowed),
		.mask_is_period(mask_is_period));
	fabric_model far_end (.core_clk(core_clk), .rc_val(rc_val), .global_clk(global_clk),
		.bus_clk_app(bus_clk_app), .routed_ctl_in(routed_ctl_in));

	always #10 core_clk = ~core_clk;
	// Ceiling well above the roughly 1200 cycles the tests need
	always @(posedge core_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 30000)
		begin
			n_fail = n_fail + 1;
			conclude();
		end
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : conclude

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked = samples_checked + 1;
		if (seen !== exp)
		begin
			n_fail = n_fail + 1;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge core_clk);
			k++;
		end
		while (pready !== 1'b1);
		check(32'(k), 32'd2);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic count(input int len, input logic [3:0] tgl, input int half, output int n0, output int n1);
		n0 = 0;
		n1 = 0;
		for (int i = 0; i < len; i++)
		begin
			if (half > 0)
				rc_val <= ((i / half) % 2 == 1 && i < len - 12) ? tgl : 4'h0;
			@(posedge core_clk);
			n0 += (tgl == 4'h8) ? clk_tick[0] : clk_tick[2];
			n1 += (tgl == 4'h0) ? fifo1_tick : fifo0_tick;
		end
	endtask : count

	// Tick model: a source rise seen in one cycle gives a tick in the next
	always @(negedge core_clk)
	begin : tick_model
		logic s;
		s = ((src_i == `SRC_BUS) ? bus_clk_app : global_clk[src_i[2:0]]) ^ inv_s;
		if (chk_on)
			check(32'(clk_tick[ci]), 32'(h1 & ~h2 & gate));
		h2 = h1;
		h1 = s;
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		logic [31:0] mdl [6];
		int n0, n1;
		cell_clkrst_pkg::clk_cfg_t cc;
		cell_clkrst_pkg::rst_cfg_t rc;
		cell_clkrst_pkg::misc_cfg_t mc;
		repeat (3) @(posedge core_clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		for (int i = 0; i < 6; i++)
		begin
			apb(1'b0, 8'(i * 4), 32'h0000_0000);
			check(rd, 32'h0000_0000);
			mdl[i] = 32'h0000_0000;
		end
		for (int i = 0; i < 18; i++)
		begin
			rnd = lfsr(rnd);
			apb(1'b1, 8'((i % 6) * 4), (i < 12) ? rnd : 32'h0000_0000);
			mdl[i % 6] = (i < 12) ? rnd & (((i % 6) < 4) ? 32'h0000_03ff : (((i % 6) == 4) ? 32'h0000_0fff
				: 32'h0000_01ff)) : 32'h0000_0000;
			apb(1'b0, 8'((i % 6) * 4), 32'h0000_0000);
			check(rd, mdl[i % 6]);
			check(32'(err), 32'h0);
		end
		apb(1'b1, `OFS_STATE, 32'hffff_ffff);
		check(32'(err), 32'h1);
		apb(1'b0, 8'h1c, 32'h0000_0000);
		check(32'(err), 32'h1);
		check(rd, `RD_ZERO);
		$display("test registers done");
		for (int i = 0; i < 12; i++)
		begin
			rnd = lfsr(rnd);
			cc = '0;
			cc.clk_sel = (rnd[3:0] > `SRC_BUS) ? `SRC_BUS : rnd[3:0];
			cc.clk_inv = rnd[4];
			cc.en_sel = rnd[6:5];
			cc.en_inv = rnd[7];
			cc.en_mode = cell_clkrst_pkg::en_mode_t'((i % 3 == 2) ? 2'h3 : 2'(i % 3));
			rc_val <= rnd[11:8];
			apb(1'b1, 8'((i % 4) * 4), 32'(cc));
			ci = 2'(i % 4);
			src_i = cc.clk_sel;
			inv_s = cc.clk_inv;
			gate = (cc.en_mode == cell_clkrst_pkg::EN_ON) | ((cc.en_mode == cell_clkrst_pkg::EN_LEVEL)
				& (rc_val[cc.en_sel] ^ cc.en_inv));
			repeat (4) @(posedge core_clk);
			chk_on = 1'b1;
			repeat (40) @(posedge core_clk);
			chk_on = 1'b0;
		end
		$display("test clock select done");
		rc_val <= 4'h0;
		cc = '0;
		cc.clk_sel = `SRC_BUS;
		cc.en_sel = 2'h1;
		cc.en_mode = cell_clkrst_pkg::EN_EDGE;
		apb(1'b1, `OFS_CLK_CFG_DP, 32'(cc));
		repeat (3) @(posedge core_clk);
		count(112, 4'h2, 10, n0, n1);
		check(32'(n0), 32'd5);
		check(32'(n1), 32'd5);
		cc.en_mode = cell_clkrst_pkg::EN_OFF;
		apb(1'b1, `OFS_CLK_CFG_DP, 32'(cc));
		mc = '0;
		mc.fifo1_fast = 1'b1;
		mc.ext_sel = 2'h3;
		mc.ext_sync = 1'b1;
		apb(1'b1, `OFS_MISC_CFG, 32'(mc));
		repeat (3) @(posedge core_clk);
		count(40, 4'h0, 0, n0, n1);
		check(32'(n1 >= 19 && n1 <= 21), 32'h1);
		check(32'(n0), 32'd0);
		cc.clk_sel = `SRC_EXT;
		cc.en_mode = cell_clkrst_pkg::EN_ON;
		apb(1'b1, `OFS_CLK_CFG_LA0, 32'(cc));
		repeat (3) @(posedge core_clk);
		count(60, 4'h8, 6, n0, n1);
		check(32'(n0), 32'd4);
		check(32'(n1), 32'd0);
		cc.clk_sel = `SRC_BUS;
		apb(1'b1, `OFS_CLK_CFG_DP, 32'(cc));
		mc = '0;
		mc.fifo0_inv = 1'b1;
		mc.ext_sel = 2'h3;
		apb(1'b1, `OFS_MISC_CFG, 32'(mc));
		repeat (3) @(posedge core_clk);
		count(60, 4'h8, 6, n0, n1);
		check(32'(n0), 32'd4);
		check(32'(n1 >= 29 && n1 <= 31), 32'h1);
		$display("test enable modes done");
		for (int i = 0; i < 10; i++)
		begin
			rnd = lfsr(rnd);
			rc = rnd[11:0];
			rc.reset_scheme_select = (i % 4 != 0);
			rc_val <= rnd[15:12];
			apb(1'b1, `OFS_RST_CFG, 32'(rc));
			repeat (3) @(posedge core_clk);
			check(32'({la_reset, dp_reset, st_reset, ctl_reset}), 32'({4{rc.reset_scheme_select}}
				& {rc_val[rc.la_rst_sel] ^ rc.la_rst_pol, rc_val[rc.dp_rst_sel] ^ rc.dp_rst_pol,
				rc.st_rst_en & (rc_val[rc.sc_rst_sel] ^ rc.sc_rst_pol),
				rc.ctl_rst_en & (rc_val[rc.sc_rst_sel] ^ rc.sc_rst_pol)}));
		end
		for (int i = 0; i < 4; i++)
		begin
			mc = '0;
			mc.counter_mode = i[0];
			mc.sync_mode = i[1];
			apb(1'b1, `OFS_MISC_CFG, 32'(mc));
			repeat (3) @(posedge core_clk);
			check(32'({status_irq_allowed, mask_is_period}), 32'({~(i[0] | i[1]), i[0]}));
			apb(1'b0, `OFS_STATE, 32'h0000_0000);
			check(rd & 32'h0000_0004, {29'h0, ~(i[0] | i[1]), 2'h0});
		end
		$display("test resets and modes done");
		conclude();
	end
endmodule : testbench
`default_nettype wire

// File: logic/cell_clkrst_defines.svh
// Register offsets, field widths and reset values of the logic cell clock/reset control
`ifndef CELL_CLKRST_DEFINES_SVH
`define CELL_CLKRST_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_CLK_CFG_LA0 8'h00
`define OFS_CLK_CFG_LA1 8'h04
`define OFS_CLK_CFG_DP 8'h08
`define OFS_CLK_CFG_SC 8'h0C
`define OFS_RST_CFG 8'h10
`define OFS_MISC_CFG 8'h14
`define OFS_STATE 8'h18

// ----------------------------------------------------------------
// Field widths and reset values
// ----------------------------------------------------------------
`define CLK_CFG_W 10
`define RST_CFG_W 12
`define MISC_CFG_W 9
`define CLK_CFG_RST 10'h000
`define RST_CFG_RST 12'h000
`define MISC_CFG_RST 9'h000
`define NUM_CIRCUITS 4
`define NUM_SOURCES 10
`define SRC_BUS 4'h8
`define SRC_EXT 4'h9
`define CIR_DP 2
`define RD_ZERO 32'h0000_0000

`endif

// File: logic/cell_clkrst_pkg.sv
// Types shared by the logic cell clock/reset control
`default_nettype none

package cell_clkrst_pkg;

	typedef enum logic [1:0]
	{
		EN_OFF = 2'h0,
		EN_ON = 2'h1,
		EN_EDGE = 2'h2,
		EN_LEVEL = 2'h3
	} en_mode_t;

	typedef struct packed
	{
		logic [3:0] clk_sel;
		logic clk_inv;
		logic [1:0] en_sel;
		logic en_inv;
		en_mode_t en_mode;
	} clk_cfg_t;

	typedef struct packed
	{
		logic la_rst_pol;
		logic [1:0] la_rst_sel;
		logic ctl_rst_en;
		logic st_rst_en;
		logic sc_rst_pol;
		logic [1:0] sc_rst_sel;
		logic dp_rst_pol;
		logic [1:0] dp_rst_sel;
		logic reset_scheme_select;
	} rst_cfg_t;

	typedef struct packed
	{
		logic sync_mode;
		logic counter_mode;
		logic fifo1_fast;
		logic fifo0_fast;
		logic fifo1_inv;
		logic fifo0_inv;
		logic ext_sync;
		logic [1:0] ext_sel;
	} misc_cfg_t;

endpackage : cell_clkrst_pkg

`default_nettype wire

// File: logic/logic_cell_clock_reset_ctrl.sv
// Clock select/enable and routed reset control of one programmable logic cell
//
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "cell_clkrst_defines.svh"

module logic_cell_clock_reset_ctrl
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	// Clock sources and routed control inputs
	input wire logic [7:0] global_clk,
	input wire logic bus_clk_app,
	input wire logic [3:0] routed_ctl_in,
	// Gated clock ticks: logic array 0, logic array 1, datapath, status/control
	output logic [3:0] clk_tick,
	output logic fifo0_tick,
	output logic fifo1_tick,
	// Routed resets and mode outputs
	output logic la_reset,
	output logic dp_reset,
	output logic st_reset,
	output logic ctl_reset,
	output logic status_irq_allowed,
	output logic mask_is_period
);

	// ----------------------------------------------------------------
	// Reset synchroniser
	// ----------------------------------------------------------------
	logic rst_meta_r;
	logic rst_n_s_r;

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rst_meta_r <= 1'b0;
			rst_n_s_r <= 1'b0;
		end
		else
		begin
			rst_meta_r <= 1'b1;
			rst_n_s_r <= rst_meta_r;
		end
	end

	// Routing drivers into the cell read as zero until reset is released
	logic [3:0] routed_ctl_input;
	logic [7:0] gclk_in;
	logic bus_in;
	assign routed_ctl_input = routed_ctl_in & {4{rst_n_s_r}};
	assign gclk_in = global_clk & {8{rst_n_s_r}};
	assign bus_in = bus_clk_app & rst_n_s_r;

	// ----------------------------------------------------------------
	// Configuration registers and APB slave
	// ----------------------------------------------------------------
	cell_clkrst_pkg::clk_cfg_t clk_cfg_r [`NUM_CIRCUITS];
	cell_clkrst_pkg::rst_cfg_t rst_cfg_r;
	cell_clkrst_pkg::misc_cfg_t misc_cfg_r;
	logic pready_r;
	logic [31:0] prdata_r;
	logic pslverr_r;
	logic wr_en;
	logic [31:0] rd_nxt;
	logic hit;
	logic [31:0] state_word;

	assign wr_en = psel & penable & pready_r & pwrite & ~pslverr_r;

	always_comb
	begin
		hit = 1'b1;
		rd_nxt = `RD_ZERO;
		unique case (paddr)
			`OFS_CLK_CFG_LA0: rd_nxt[`CLK_CFG_W-1:0] = clk_cfg_r[0];
			`OFS_CLK_CFG_LA1: rd_nxt[`CLK_CFG_W-1:0] = clk_cfg_r[1];
			`OFS_CLK_CFG_DP: rd_nxt[`CLK_CFG_W-1:0] = clk_cfg_r[2];
			`OFS_CLK_CFG_SC: rd_nxt[`CLK_CFG_W-1:0] = clk_cfg_r[3];
			`OFS_RST_CFG: rd_nxt[`RST_CFG_W-1:0] = rst_cfg_r;
			`OFS_MISC_CFG: rd_nxt[`MISC_CFG_W-1:0] = misc_cfg_r;
			`OFS_STATE: rd_nxt = state_word;
			default: hit = 1'b0;
		endcase
	end

	// Two-cycle access phase gives a registered answer
	always_ff @(posedge core_clk or negedge rst_n_s_r)
	begin
		if (!rst_n_s_r)
		begin
			pready_r <= 1'b0;
			prdata_r <= `RD_ZERO;
			pslverr_r <= 1'b0;
		end
		else
		begin
			pready_r <= psel & penable & ~pready_r;
			pslverr_r <= psel & penable & ~pready_r & (~hit | (pwrite & (paddr == `OFS_STATE)));
			prdata_r <= (psel & penable & ~pready_r & ~pwrite) ? rd_nxt : `RD_ZERO;
		end
	end

	// All configuration clears to zero at power-on
	always_ff @(posedge core_clk or negedge rst_n_s_r)
	begin
		if (!rst_n_s_r)
		begin
			for (int i = 0; i < `NUM_CIRCUITS; i++)
				clk_cfg_r[i] <= `CLK_CFG_RST;
			rst_cfg_r <= `RST_CFG_RST;
			misc_cfg_r <= `MISC_CFG_RST;
		end
		else if (wr_en)
		begin
			for (int i = 0; i < `NUM_CIRCUITS; i++)
				if (paddr == 8'(i * 4))
					clk_cfg_r[i] <= pwdata[`CLK_CFG_W-1:0];
			if (paddr == `OFS_RST_CFG)
				rst_cfg_r <= pwdata[`RST_CFG_W-1:0];
			if (paddr == `OFS_MISC_CFG)
				misc_cfg_r <= pwdata[`MISC_CFG_W-1:0];
		end
	end

	// ----------------------------------------------------------------
	// External clock selection
	// ----------------------------------------------------------------
	logic ext_meta_r;
	logic ext_sync_r;
	logic ext_clk;

	always_ff @(posedge core_clk or negedge rst_n_s_r)
	begin
		if (!rst_n_s_r)
		begin
			ext_meta_r <= 1'b0;
			ext_sync_r <= 1'b0;
		end
		else
		begin
			ext_meta_r <= routed_ctl_input[misc_cfg_r.ext_sel];
			ext_sync_r <= ext_meta_r;
		end
	end

	assign ext_clk = misc_cfg_r.ext_sync ? ext_sync_r : routed_ctl_input[misc_cfg_r.ext_sel];

	logic [`NUM_SOURCES-1:0] src_vec;
	assign src_vec = {ext_clk, bus_in, gclk_in};

	// ----------------------------------------------------------------
	// Clock select/enable circuits
	// ----------------------------------------------------------------
	// Clocks are modelled as rising-edge ticks on core_clk; no real clock gating,
	// so sources faster than half of core_clk are not followed.
	logic [3:0] clk_tick_r;
	logic [3:0] en_level;
	logic [3:0] en_prev_r;
	logic [3:0] src_prev_r;
	logic [3:0] src_now;
	logic [3:0] raw_tick;
	logic [3:0] gate;
	logic dp_fall_tick;
	logic dp_en_ok;

	for (genvar g = 0; g < `NUM_CIRCUITS; g++)
	begin : g_circ
		assign src_now[g] = (clk_cfg_r[g].clk_sel < `NUM_SOURCES) &
			(src_vec[clk_cfg_r[g].clk_sel] ^ clk_cfg_r[g].clk_inv);
		assign raw_tick[g] = src_now[g] & ~src_prev_r[g];
		assign en_level[g] = routed_ctl_input[clk_cfg_r[g].en_sel] ^ clk_cfg_r[g].en_inv;

		always_comb
		begin
			unique case (clk_cfg_r[g].en_mode)
				cell_clkrst_pkg::EN_OFF: gate[g] = 1'b0;
				cell_clkrst_pkg::EN_ON: gate[g] = raw_tick[g];
				cell_clkrst_pkg::EN_EDGE: gate[g] = raw_tick[g] & en_level[g] & ~en_prev_r[g];
				cell_clkrst_pkg::EN_LEVEL: gate[g] = raw_tick[g] & en_level[g];
			endcase
		end

		always_ff @(posedge core_clk or negedge rst_n_s_r)
		begin
			if (!rst_n_s_r)
				src_prev_r[g] <= 1'b0;
			else
				src_prev_r[g] <= src_now[g];
		end

		// Enable is sampled only on the selected clock, as a flop clocked by it would
		always_ff @(posedge core_clk or negedge rst_n_s_r)
		begin
			if (!rst_n_s_r)
				en_prev_r[g] <= 1'b0;
			else if (raw_tick[g])
				en_prev_r[g] <= en_level[g];
		end

		always_ff @(posedge core_clk or negedge rst_n_s_r)
		begin
			if (!rst_n_s_r)
				clk_tick_r[g] <= 1'b0;
			else
				clk_tick_r[g] <= gate[g];
		end

		a_off_no_tick: assert property (@(posedge core_clk) disable iff (!rst_n_s_r)
			(clk_cfg_r[g].en_mode == cell_clkrst_pkg::EN_OFF) |=> !clk_tick_r[g])
			else $error("tick delivered in off mode");
		a_on_free_run: assert property (@(posedge core_clk) disable iff (!rst_n_s_r)
			(clk_cfg_r[g].en_mode == cell_clkrst_pkg::EN_ON) && raw_tick[g] |=> clk_tick_r[g])
			else $error("source edge lost in on mode");
		a_level_gating: assert property (@(posedge core_clk) disable iff (!rst_n_s_r)
			clk_tick_r[g] && ($past(clk_cfg_r[g].en_mode) == cell_clkrst_pkg::EN_LEVEL)
			|-> $past(en_level[g]))
			else $error("level mode passed clock with enable low");
		a_edge_once: assert property (@(posedge core_clk) disable iff (!rst_n_s_r)
			$rose(clk_tick_r[g]) && (clk_cfg_r[g].en_mode == cell_clkrst_pkg::EN_EDGE)
			&& $stable(clk_cfg_r[g]) |-> en_prev_r[g] && !gate[g])
			else $error("edge mode gave more than one tick per rise");
	end

	// Inverted FIFO clock: falling edge of the datapath source under the same enable
	assign dp_fall_tick = ~src_now[`CIR_DP] & src_prev_r[`CIR_DP];
	always_comb
	begin
		unique case (clk_cfg_r[`CIR_DP].en_mode)
			cell_clkrst_pkg::EN_OFF: dp_en_ok = 1'b0;
			cell_clkrst_pkg::EN_ON: dp_en_ok = 1'b1;
			cell_clkrst_pkg::EN_EDGE: dp_en_ok = en_level[`CIR_DP] & ~en_prev_r[`CIR_DP];
			cell_clkrst_pkg::EN_LEVEL: dp_en_ok = en_level[`CIR_DP];
		endcase
	end

	// ----------------------------------------------------------------
	// FIFO clocks
	// ----------------------------------------------------------------
	logic bus_prev_r;
	logic bus_tick;
	logic fifo0_tick_r;
	logic fifo1_tick_r;
	assign bus_tick = bus_in & ~bus_prev_r;

	always_ff @(posedge core_clk or negedge rst_n_s_r)
	begin
		if (!rst_n_s_r)
		begin
			bus_prev_r <= 1'b0;
			fifo0_tick_r <= 1'b0;
			fifo1_tick_r <= 1'b0;
		end
		else
		begin
			bus_prev_r <= bus_in;
			fifo0_tick_r <= misc_cfg_r.fifo0_fast ? bus_tick :
				(misc_cfg_r.fifo0_inv ? dp_fall_tick & dp_en_ok : gate[`CIR_DP]);
			fifo1_tick_r <= misc_cfg_r.fifo1_fast ? bus_tick :
				(misc_cfg_r.fifo1_inv ? dp_fall_tick & dp_en_ok : gate[`CIR_DP]);
		end
	end

	a_fifo_fast: assert property (@(posedge core_clk) disable iff (!rst_n_s_r)
		misc_cfg_r.fifo0_fast && bus_tick |=> fifo0_tick)
		else $error("fast fifo did not follow bus clock");
	a_fifo_follow: assert property (@(posedge core_clk) disable iff (!rst_n_s_r)
		!misc_cfg_r.fifo1_fast && !misc_cfg_r.fifo1_inv |=> fifo1_tick == clk_tick_r[`CIR_DP])
		else $error("fifo clock departed from datapath clock");

	// ----------------------------------------------------------------
	// Routed resets and mode outputs
	// ----------------------------------------------------------------
	// Only the logic array, datapath and status/control resets leave here; data registers,
	// mask/period and aux control have no reset line, so routed reset cannot touch them.
	// No RAM is kept here, so nothing depends on power-on RAM contents.
	logic la_reset_r;
	logic dp_reset_r;
	logic st_reset_r;
	logic ctl_reset_r;
	logic irq_ok_r;
	logic mask_period_r;
	logic std_mode;
	logic sc_rst;
	assign std_mode = rst_cfg_r.reset_scheme_select;
	assign sc_rst = routed_ctl_input[rst_cfg_r.sc_rst_sel] ^ rst_cfg_r.sc_rst_pol;

	always_ff @(posedge core_clk or negedge rst_n_s_r)
	begin
		if (!rst_n_s_r)
		begin
			la_reset_r <= 1'b0;
			dp_reset_r <= 1'b0;
			st_reset_r <= 1'b0;
			ctl_reset_r <= 1'b0;
		end
		else
		begin
			la_reset_r <= std_mode & (routed_ctl_input[rst_cfg_r.la_rst_sel] ^ rst_cfg_r.la_rst_pol);
			dp_reset_r <= std_mode & (routed_ctl_input[rst_cfg_r.dp_rst_sel] ^ rst_cfg_r.dp_rst_pol);
			st_reset_r <= std_mode & rst_cfg_r.st_rst_en & sc_rst;
			ctl_reset_r <= std_mode & rst_cfg_r.ctl_rst_en & sc_rst;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n_s_r)
	begin
		if (!rst_n_s_r)
		begin
			irq_ok_r <= 1'b0;
			mask_period_r <= 1'b0;
		end
		else
		begin
			irq_ok_r <= ~misc_cfg_r.counter_mode & ~misc_cfg_r.sync_mode;
			mask_period_r <= misc_cfg_r.counter_mode;
		end
	end

	a_legacy_no_rst: assert property (@(posedge core_clk) disable iff (!rst_n_s_r)
		!std_mode |=> !dp_reset && !st_reset && !ctl_reset && !la_reset)
		else $error("routed reset active in legacy mode");
	a_dp_rst_sel: assert property (@(posedge core_clk) disable iff (!rst_n_s_r)
		std_mode |=> dp_reset == ($past(routed_ctl_input[rst_cfg_r.dp_rst_sel]) ^ $past(rst_cfg_r.dp_rst_pol)))
		else $error("datapath reset select or polarity wrong");
	a_sc_rst_enable: assert property (@(posedge core_clk) disable iff (!rst_n_s_r)
		!rst_cfg_r.st_rst_en |=> !st_reset)
		else $error("status reset not gated by its enable");
	a_counter_no_irq: assert property (@(posedge core_clk) disable iff (!rst_n_s_r)
		misc_cfg_r.counter_mode |=> !status_irq_allowed && mask_is_period)
		else $error("interrupt allowed in counter mode");
	a_sync_no_mask: assert property (@(posedge core_clk) disable iff (!rst_n_s_r)
		misc_cfg_r.sync_mode |=> !status_irq_allowed)
		else $error("mask usable in sync mode");

	// ----------------------------------------------------------------
	// Read-back state and outputs
	// ----------------------------------------------------------------
	assign state_word = {16'h0000, en_level, src_now, ext_clk, la_reset_r, dp_reset_r,
		st_reset_r, ctl_reset_r, irq_ok_r, fifo1_tick_r, fifo0_tick_r};

	assign pready = pready_r;
	assign prdata = prdata_r;
	assign pslverr = pslverr_r;
	assign clk_tick = clk_tick_r;
	assign fifo0_tick = fifo0_tick_r;
	assign fifo1_tick = fifo1_tick_r;
	assign la_reset = la_reset_r;
	assign dp_reset = dp_reset_r;
	assign st_reset = st_reset_r;
	assign ctl_reset = ctl_reset_r;
	assign status_irq_allowed = irq_ok_r;
	assign mask_is_period = mask_period_r;

endmodule : logic_cell_clock_reset_ctrl

`default_nettype wire
